// ==== ldm_pkg.sv ====
// constants, modes and carrier types for the dimming mode controller
package ldm_pkg;

   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int CNT_W = 23;

   // times in their own units
   localparam int unsigned T_START_MS = 1;
   localparam int unsigned T_REEN_US = 300;
   localparam int unsigned T_STATIC_MS = 15;
   localparam int unsigned T_RAMP_MS = 5;
   localparam int unsigned T_FIRST_ON_US = 1;
   localparam int unsigned T_EN_MIN_US = 5;
   localparam int unsigned T_OFF_MS = 20;

   // cycle counts derived from the clock rate
   localparam int unsigned START_CYC = T_START_MS * 1000 * CYC_PER_US;
   localparam int unsigned REEN_CYC = T_REEN_US * CYC_PER_US;
   localparam int unsigned STATIC_CYC = T_STATIC_MS * 1000 * CYC_PER_US;
   localparam int unsigned OFF_CYC = T_OFF_MS * 1000 * CYC_PER_US;
   localparam int unsigned RAMP_FULL_CYC = T_RAMP_MS * 1000 * CYC_PER_US;
   localparam logic [7:0] REF_FULL = 8'hFF;
   localparam logic [11:0] RAMP_STEP_CYC = 12'(RAMP_FULL_CYC / 255);
   localparam logic [CNT_W-1:0] FIRST_ON_CYC = CNT_W'(T_FIRST_ON_US * CYC_PER_US);
   localparam logic [CNT_W-1:0] EN_MIN_CYC = CNT_W'(T_EN_MIN_US * CYC_PER_US);

   // hybrid split point 12.5 % of 256 codes, hysteresis one code (0.4 %)
   localparam logic [7:0] HYB_FLOOR = 8'h20;
   localparam logic [7:0] HYB_HYST = 8'h01;

   // register map, byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_LEVEL = 12'h008;
   localparam logic [11:0] ADDR_FAULT = 12'h00C;
   localparam logic CTRL_RESET = 1'b0;

   typedef enum logic [2:0] {
      MD_NONE = 3'b000,
      MD_PULSE = 3'b001,
      MD_ANALOG = 3'b010,
      MD_HYBRID = 3'b011,
      MD_FLEX = 3'b100
   } ldm_mode_t;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_WAIT = 2'b01,
      ST_DECODE = 2'b10,
      ST_RUN = 2'b11
   } ldm_state_t;

   // analog comparator results, one bit each
   typedef struct packed {
      logic ovp_cv;
      logic ovp_open;
      logic ovp_hold;
      logic bb_short;
      logic sense_over;
      logic comp_clamp;
      logic switch_fault;
      logic thermal;
   } ldm_fault_t;

endpackage

// ==== ldm_sync.sv ====
// three-stage input synchroniser with second/third stage agreement
`timescale 1ns/10ps
`default_nettype none
module ldm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } ldm_sync_t;

   ldm_sync_t sync_reg;
   ldm_sync_t sync_next;

   always_comb begin
      sync_next = sync_reg;
      sync_next.s1 = d;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
   end

   // a bit only moves once stages two and three agree
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            sync_reg.s1[i] <= 1'b0;
            sync_reg.s2[i] <= 1'b0;
            sync_reg.s3[i] <= 1'b0;
            sync_reg.out[i] <= 1'b0;
         end else begin
            sync_reg.s1[i] <= sync_next.s1[i];
            sync_reg.s2[i] <= sync_next.s2[i];
            sync_reg.s3[i] <= sync_next.s3[i];
            if (sync_reg.s2[i] == sync_reg.s3[i]) begin
               sync_reg.out[i] <= sync_reg.s3[i];
            end
         end
      end
   end

   assign q = sync_reg.out;
endmodule
`default_nettype wire

// ==== ldm_dimming_ctrl.sv ====
// dimming mode decoder, duty meter, reference ramp, fault reactions, apb registers
//
// What this block does
// - start 1 ms after supply, 300 us re-enable
// - mode decoded from enable and level inputs
// - accept enable pulses down to 150 ns
// - enable rising edge starts switching in pulse mode
// - enable falling edge stops switching, zero current
// - first level pulse of 1 us enters analog
// - duty measured through end of second period
// - reference linear in duty, 90 % to 180 mV
// - static level input means 100 % or 0 %
// - first full-scale reference change takes 5 ms
// - duty quantised to 8 bits
// - hybrid entered by enable falling edge, level low
// - level rising edge ends hybrid until re-enable
// - hybrid below 12.5 % uses internal pulse generator
// - internal generator has 0.4 % hysteresis
// - flexible mode: enable gates, level sets reference
// - constant-voltage above 1.15 V, stop above 1.4 V
// - open load fault, resume below 1.35 V
// - buck-boost short fault, switch at minimum on-time
// - sense over 300 mV fault stops switching
// - comp clamp fault keeps switching, current limited
// - switch or thermal fault stops switching
// - reference full scale code equals 200 mV
`timescale 1ns/10ps
`default_nettype none
module ldm_dimming_ctrl
   import ldm_pkg::*;
#(
   parameter int unsigned START_CYCLES = START_CYC,
   parameter int unsigned REEN_CYCLES = REEN_CYC,
   parameter int unsigned STATIC_CYCLES = STATIC_CYC,
   parameter int unsigned OFF_CYCLES = OFF_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic EN_PWM_IN,
   input wire logic LEVEL_DIM_IN,
   input wire logic SUPPLY_OK_IN,
   input wire ldm_fault_t FAULT_CMP_IN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic SWITCH_EN,
   output logic MIN_ON_TIME,
   output logic CV_MODE,
   output logic [7:0] VREF_CODE,
   output logic [2:0] DIM_MODE,
   output logic FAULT_N_O,
   output logic FAULT_N_OE
);
   localparam logic [CNT_W-1:0] START_LIM = CNT_W'(START_CYCLES - 1);
   localparam logic [CNT_W-1:0] REEN_LIM = CNT_W'(REEN_CYCLES - 1);
   localparam logic [CNT_W-1:0] STATIC_LIM = CNT_W'(STATIC_CYCLES);
   localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(OFF_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   typedef struct packed {
      ldm_state_t st;
      ldm_mode_t mode;
      logic first_pwr;
      logic hyb_lock;
      logic en_d;
      logic lvl_d;
      logic meas_d;
      logic [CNT_W-1:0] tmr;
      logic [CNT_W-1:0] off_cnt;
      logic [CNT_W-1:0] hi_cnt;
      logic [CNT_W-1:0] per_cnt;
      logic [CNT_W-1:0] m_hi;
      logic [CNT_W-1:0] m_per;
      logic [CNT_W-1:0] gen_cnt;
      logic [1:0] periods;
      logic div_busy;
      logic [3:0] div_cnt;
      logic [CNT_W:0] div_rem;
      logic [7:0] div_q;
      logic [7:0] duty;
      logic duty_valid;
      logic [7:0] vref;
      logic ramping;
      logic [11:0] ramp_cnt;
      logic pwm_region;
      logic open_lat;
      logic force_off;
      logic gate;
      logic fault;
      logic min_on;
      logic cv;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ldm_core_t;

   ldm_core_t core_reg;
   ldm_core_t core_next;

   logic [10:0] pins_sync;
   logic en;
   logic lvl;
   logic sup;
   ldm_fault_t flt;

   // enable, level, supply and fault pins come from the outside world, so each is synchronised
   ldm_sync #(.W(11)) u_sync (
      .clk(REF_CLK),
      .rst(RST),
      .d({EN_PWM_IN, LEVEL_DIM_IN, SUPPLY_OK_IN, FAULT_CMP_IN}),
      .q(pins_sync)
   );

   assign en = pins_sync[10];
   assign lvl = pins_sync[9];
   assign sup = pins_sync[8];
   assign flt = ldm_fault_t'(pins_sync[7:0]);

   always_comb begin
      logic meas;
      logic meas_rise;
      logic en_fall;
      logic lvl_rise;
      logic lvl_fall;
      logic gen_on;
      logic led_on;
      logic stop;
      logic q_bit;
      logic [CNT_W:0] rem2;
      logic [7:0] tgt;
      core_next = core_reg;
      meas = (core_reg.mode == MD_HYBRID) ? en : lvl;
      meas_rise = meas & ~core_reg.meas_d;
      en_fall = ~en & core_reg.en_d;
      lvl_rise = lvl & ~core_reg.lvl_d;
      lvl_fall = ~lvl & core_reg.lvl_d;
      q_bit = 1'b0;
      rem2 = '0;
      tgt = core_reg.vref;
      led_on = 1'b0;
      gen_on = 1'b0;
      stop = 1'b0;
      core_next.en_d = en;
      core_next.lvl_d = lvl;
      core_next.meas_d = meas;

      // duty meter: period from rising edge to rising edge
      if (meas_rise) begin
         core_next.per_cnt = CNT_ONE;
         core_next.hi_cnt = CNT_ONE;
         if (core_reg.periods != 2'b11) begin
            core_next.periods = core_reg.periods + 2'b01;
         end
         if (core_reg.periods >= 2'b10) begin
            core_next.m_hi = core_reg.hi_cnt;
            core_next.m_per = core_reg.per_cnt;
            if (core_reg.hi_cnt >= core_reg.per_cnt) begin
               core_next.duty = REF_FULL;
               core_next.duty_valid = 1'b1;
            end else begin
               core_next.div_busy = 1'b1;
               core_next.div_cnt = 4'h8;
               core_next.div_rem = {1'b0, core_reg.hi_cnt};
               core_next.div_q = 8'h00;
            end
         end
      end else if (core_reg.per_cnt < STATIC_LIM) begin
         core_next.per_cnt = core_reg.per_cnt + CNT_ONE;
         if (meas) begin
            core_next.hi_cnt = core_reg.hi_cnt + CNT_ONE;
         end
      end else if (core_reg.st == ST_RUN) begin
         // no edge for a long time: low reads as full, high as nothing
         core_next.duty = meas ? 8'h00 : REF_FULL;
         core_next.duty_valid = 1'b1;
         core_next.periods = 2'b00;
      end

      // restoring divide, one quotient bit per cycle: 256*hi/period
      if (core_reg.div_busy) begin
         rem2 = {core_reg.div_rem[CNT_W-1:0], 1'b0};
         if (rem2 >= {1'b0, core_reg.m_per}) begin
            rem2 = rem2 - {1'b0, core_reg.m_per};
            q_bit = 1'b1;
         end
         core_next.div_rem = rem2;
         core_next.div_q = {core_reg.div_q[6:0], q_bit};
         core_next.div_cnt = core_reg.div_cnt - 4'h1;
         if (core_reg.div_cnt == 4'h1) begin
            core_next.div_busy = 1'b0;
            core_next.duty = {core_reg.div_q[6:0], q_bit};
            core_next.duty_valid = 1'b1;
         end
      end

      // internal generator copies measured period and high time
      if (core_reg.gen_cnt + CNT_ONE >= core_reg.m_per) begin
         core_next.gen_cnt = '0;
      end else begin
         core_next.gen_cnt = core_reg.gen_cnt + CNT_ONE;
      end
      gen_on = core_reg.gen_cnt < core_reg.m_hi;

      // low-brightness region with one code of hysteresis
      if (core_reg.duty < HYB_FLOOR) begin
         core_next.pwm_region = 1'b1;
      end else if (core_reg.duty >= HYB_FLOOR + HYB_HYST) begin
         core_next.pwm_region = 1'b0;
      end

      // long enable low means disabled
      if (en) begin
         core_next.off_cnt = '0;
      end else if (core_reg.off_cnt != OFF_LIM) begin
         core_next.off_cnt = core_reg.off_cnt + CNT_ONE;
      end

      unique case (core_reg.st)
         ST_OFF: begin
            core_next.mode = MD_NONE;
            core_next.vref = 8'h00;
            core_next.hyb_lock = 1'b0;
            core_next.duty_valid = 1'b0;
            if (en) begin
               core_next.tmr = core_reg.tmr + CNT_ONE;
               if (core_reg.tmr >= EN_MIN_CYC - CNT_ONE) begin
                  core_next.st = ST_WAIT;
                  core_next.tmr = '0;
               end
            end else begin
               core_next.tmr = '0;
            end
         end
         ST_WAIT: begin
            core_next.tmr = core_reg.tmr + CNT_ONE;
            if (core_reg.tmr >= (core_reg.first_pwr ? START_LIM : REEN_LIM)) begin
               core_next.st = ST_DECODE;
               core_next.first_pwr = 1'b0;
               core_next.periods = 2'b00;
               core_next.ramping = 1'b1;
               core_next.ramp_cnt = 12'h000;
            end
         end
         ST_DECODE: begin
            if (lvl_fall && core_reg.hi_cnt >= FIRST_ON_CYC) begin
               core_next.st = ST_RUN;
               core_next.mode = MD_ANALOG;
            end else if (en_fall) begin
               core_next.st = ST_RUN;
               if (lvl || core_reg.hyb_lock) begin
                  core_next.mode = MD_PULSE;
               end else begin
                  core_next.mode = MD_HYBRID;
                  core_next.periods = 2'b00;
               end
            end
            if (core_reg.off_cnt == OFF_LIM) begin
               core_next.st = ST_OFF;
            end
         end
         ST_RUN: begin
            unique case (core_reg.mode)
               MD_PULSE: begin
                  if (lvl_fall && core_reg.hi_cnt >= FIRST_ON_CYC) begin
                     core_next.mode = MD_FLEX;
                  end
               end
               MD_ANALOG: begin
                  if (en_fall) begin
                     core_next.mode = MD_FLEX;
                  end
               end
               MD_HYBRID: begin
                  if (lvl_rise) begin
                     core_next.mode = MD_FLEX;
                     core_next.hyb_lock = 1'b1;
                     core_next.periods = 2'b00;
                     core_next.duty_valid = 1'b0;
                  end
               end
               default: begin
               end
            endcase
            if (core_reg.off_cnt == OFF_LIM) begin
               core_next.st = ST_OFF;
            end
         end
      endcase

      // reference target and on/off gating per mode
      unique case (core_reg.mode)
         MD_PULSE: begin
            tgt = REF_FULL;
            led_on = en;
         end
         MD_ANALOG: begin
            tgt = core_reg.duty_valid ? core_reg.duty : core_reg.vref;
            led_on = 1'b1;
         end
         MD_FLEX: begin
            tgt = core_reg.duty_valid ? core_reg.duty : core_reg.vref;
            led_on = en;
         end
         MD_HYBRID: begin
            tgt = core_reg.pwm_region ? HYB_FLOOR : core_reg.duty;
            led_on = core_reg.pwm_region ? gen_on : 1'b1;
         end
         default: begin
            tgt = 8'h00;
            led_on = 1'b0;
         end
      endcase

      // first change after start walks one code per step, then tracks directly
      if (core_reg.st == ST_RUN) begin
         if (core_reg.ramping) begin
            if (core_reg.ramp_cnt >= RAMP_STEP_CYC - 12'h001) begin
               core_next.ramp_cnt = 12'h000;
               if (core_reg.vref < tgt) begin
                  core_next.vref = core_reg.vref + 8'h01;
               end else if (core_reg.vref > tgt) begin
                  core_next.vref = core_reg.vref - 8'h01;
               end
            end else begin
               core_next.ramp_cnt = core_reg.ramp_cnt + 12'h001;
            end
            if (core_reg.vref == tgt && (core_reg.duty_valid || core_reg.mode == MD_PULSE)) begin
               core_next.ramping = 1'b0;
            end
         end else begin
            core_next.vref = tgt;
         end
      end

      // open load latches above 1.4 V and holds until below 1.35 V
      if (flt.ovp_open) begin
         core_next.open_lat = 1'b1;
      end else if (!flt.ovp_hold) begin
         core_next.open_lat = 1'b0;
      end
      stop = core_reg.open_lat | flt.sense_over | flt.switch_fault | flt.thermal;
      core_next.gate = (core_reg.st == ST_RUN) & led_on & ~stop & ~core_reg.force_off;
      core_next.min_on = flt.bb_short & core_next.gate;
      core_next.cv = flt.ovp_cv;
      // comp clamp reports only; the current limit keeps switching safe
      core_next.fault = core_reg.open_lat | flt.bb_short | flt.sense_over | flt.comp_clamp |
         flt.switch_fault | flt.thermal;

      // apb slave, one wait state so the answer comes from flops
      core_next.pready = 1'b0;
      core_next.pslverr = 1'b0;
      if (PSEL && PENABLE && !core_reg.pready) begin
         core_next.pready = 1'b1;
         core_next.prdata = 32'h0000_0000;
         unique case (PADDR)
            ADDR_CTRL: begin
               core_next.prdata = {31'h0000_0000, core_reg.force_off};
            end
            ADDR_STATUS: begin
               core_next.prdata = {20'h00000, core_reg.pwm_region, core_reg.ramping, core_reg.duty_valid,
                  core_reg.hyb_lock, core_reg.cv, core_reg.fault, core_reg.gate, core_reg.st, core_reg.mode};
            end
            ADDR_LEVEL: begin
               core_next.prdata = {16'h0000, core_reg.vref, core_reg.duty};
            end
            ADDR_FAULT: begin
               core_next.prdata = {23'h000000, core_reg.open_lat, flt};
            end
            default: begin
               core_next.pslverr = 1'b1;
            end
         endcase
      end

      // write lands on the edge where the master sees pready high
      if (PSEL && PENABLE && PWRITE && core_reg.pready && PADDR == ADDR_CTRL) begin
         core_next.force_off = PWDATA[0];
      end

      // supply drop overrides everything and forces the long start delay
      if (!sup) begin
         core_next.st = ST_OFF;
         // enable qualification restarts once supply is back
         core_next.tmr = '0;
         core_next.first_pwr = 1'b1;
         core_next.gate = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         core_reg <= '0;
         core_reg.st <= ST_OFF;
         core_reg.mode <= MD_NONE;
         core_reg.first_pwr <= 1'b1;
         core_reg.force_off <= CTRL_RESET;
      end else begin
         core_reg <= core_next;
      end
   end

   assign PRDATA = core_reg.prdata;
   assign PREADY = core_reg.pready;
   assign PSLVERR = core_reg.pslverr;
   assign SWITCH_EN = core_reg.gate;
   assign MIN_ON_TIME = core_reg.min_on;
   assign CV_MODE = core_reg.cv;
   assign VREF_CODE = core_reg.vref;
   assign DIM_MODE = core_reg.mode;
   // open drain: the pin is only ever driven low
   assign FAULT_N_O = 1'b0;
   assign FAULT_N_OE = core_reg.fault;
endmodule
`default_nettype wire

// ==== ldm_properties.sv ====
// port-level assertions for the dimming controller
`timescale 1ns/10ps
`default_nettype none
module ldm_properties
   import ldm_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic EN_PWM_IN,
   input wire logic SUPPLY_OK_IN,
   input wire ldm_fault_t FAULT_CMP_IN,
   input wire logic SWITCH_EN,
   input wire logic MIN_ON_TIME,
   input wire logic CV_MODE,
   input wire logic [2:0] DIM_MODE,
   input wire logic FAULT_N_O,
   input wire logic FAULT_N_OE
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   a_pulse_off: assert property ((DIM_MODE == MD_PULSE && !EN_PWM_IN) [*8] |-> !SWITCH_EN)
      else $error("switch on with enable low");
   // window covers the sync latency of a pulse of two cycles or more
   a_pulse_on: assert property ($rose(SWITCH_EN) && DIM_MODE == MD_PULSE |->
      $past(EN_PWM_IN, 3) || $past(EN_PWM_IN, 4) || $past(EN_PWM_IN, 5) || $past(EN_PWM_IN, 6))
      else $error("switch on without enable");
   a_cv_follow: assert property ($stable(FAULT_CMP_IN.ovp_cv) [*8] |-> CV_MODE == FAULT_CMP_IN.ovp_cv)
      else $error("cv mode wrong");
   a_open_stop: assert property (FAULT_CMP_IN.ovp_open [*8] |-> FAULT_N_OE && !SWITCH_EN)
      else $error("open load not handled");
   a_sense_stop: assert property (FAULT_CMP_IN.sense_over [*8] |-> FAULT_N_OE && !SWITCH_EN)
      else $error("sense over not handled");
   a_hard_stop: assert property ((FAULT_CMP_IN.switch_fault || FAULT_CMP_IN.thermal) [*8] |->
      FAULT_N_OE && !SWITCH_EN)
      else $error("switch or thermal fault not handled");
   a_clamp_flag: assert property (FAULT_CMP_IN.comp_clamp [*8] |-> FAULT_N_OE)
      else $error("clamp not flagged");
   a_short_flag: assert property (FAULT_CMP_IN.bb_short [*8] |-> FAULT_N_OE)
      else $error("short not flagged");
   a_min_on_off: assert property ((!FAULT_CMP_IN.bb_short) [*8] |-> !MIN_ON_TIME)
      else $error("min on-time without short");
   a_fault_release: assert property ((FAULT_CMP_IN == 8'h00) [*8] |-> !FAULT_N_OE)
      else $error("fault pin not released");
   a_pin_low: assert property (FAULT_N_OE |-> !FAULT_N_O)
      else $error("fault pin not pulled low");
   a_supply_off: assert property ((!SUPPLY_OK_IN) [*8] |-> DIM_MODE == MD_NONE && !SWITCH_EN)
      else $error("active without supply");
   a_mode_legal: assert property (DIM_MODE <= MD_FLEX)
      else $error("bad mode code");
endmodule
bind ldm_dimming_ctrl ldm_properties i_ldm_properties (
   .REF_CLK(REF_CLK),
   .RST(RST),
   .EN_PWM_IN(EN_PWM_IN),
   .SUPPLY_OK_IN(SUPPLY_OK_IN),
   .FAULT_CMP_IN(FAULT_CMP_IN),
   .SWITCH_EN(SWITCH_EN),
   .MIN_ON_TIME(MIN_ON_TIME),
   .CV_MODE(CV_MODE),
   .DIM_MODE(DIM_MODE),
   .FAULT_N_O(FAULT_N_O),
   .FAULT_N_OE(FAULT_N_OE)
);
`default_nettype wire

// ==== ldm_host_model.sv ====
// host model making the enable and level pulse trains
`timescale 1ns/10ps
`default_nettype none
module ldm_host_model (
   input wire logic clk,
   input wire logic [15:0] en_per,
   input wire logic [15:0] en_hi,
   input wire logic [15:0] lv_per,
   input wire logic [15:0] lv_hi,
   output logic en_o,
   output logic lv_o
);
   logic [15:0] ec = 16'h0000;
   logic [15:0] lc = 16'h0000;
   initial begin
      en_o = 1'b0;
      lv_o = 1'b1;
   end
   always @(posedge clk) begin
      ec <= (ec + 16'h0001 >= en_per) ? 16'h0000 : ec + 16'h0001;
      lc <= (lc + 16'h0001 >= lv_per) ? 16'h0000 : lc + 16'h0001;
      en_o <= ec < en_hi;
      // meter needs 100 ns, so narrower level pulses are widened
      lv_o <= lc < ((lv_hi != 16'h0000 && lv_hi < 16'h0014) ? 16'h0014 : lv_hi);
   end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the dimming controller
`timescale 1ns/10ps
`default_nettype none
module testbench
   import ldm_pkg::*;
;
   localparam int P_START = 200;
   localparam int P_REEN = 100;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic SUPPLY_OK_IN = 1'b1;
   ldm_fault_t FAULT_CMP_IN = 8'h00;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h00000000;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, SWITCH_EN, MIN_ON_TIME, CV_MODE, FAULT_N_O, FAULT_N_OE, EN_PWM_IN, LEVEL_DIM_IN;
   logic [7:0] VREF_CODE;
   logic [2:0] DIM_MODE;
   logic [15:0] ep = 16'h0001, eh = 16'h0000, lp = 16'h0001, lh = 16'h0001;
   logic [31:0] rd;
   logic er;
   int miscompares = 0;
   int checked = 0;
   int n, hi;
   // fault in, then pin pull, switch enable, cv, min on-time
   logic [11:0] frow [10] = '{12'h806, 12'h608, 12'h208, 12'h004, 12'h10D, 12'h088, 12'h04C, 12'h028, 12'h018,
      12'h004};
   int hy [4] = '{3, 5, 30, 5};
   logic hx [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

   ldm_dimming_ctrl #(.START_CYCLES(P_START), .REEN_CYCLES(P_REEN), .STATIC_CYCLES(400), .OFF_CYCLES(600))
   i_ldm_dimming_ctrl (.REF_CLK(REF_CLK), .RST(RST), .EN_PWM_IN(EN_PWM_IN), .LEVEL_DIM_IN(LEVEL_DIM_IN),
      .SUPPLY_OK_IN(SUPPLY_OK_IN), .FAULT_CMP_IN(FAULT_CMP_IN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .SWITCH_EN(SWITCH_EN), .MIN_ON_TIME(MIN_ON_TIME), .CV_MODE(CV_MODE), .VREF_CODE(VREF_CODE),
      .DIM_MODE(DIM_MODE), .FAULT_N_O(FAULT_N_O), .FAULT_N_OE(FAULT_N_OE));
   ldm_host_model i_ldm_host_model (.clk(REF_CLK), .en_per(ep), .en_hi(eh), .lv_per(lp), .lv_hi(lh),
      .en_o(EN_PWM_IN), .lv_o(LEVEL_DIM_IN));

   initial begin
      forever #2.5 REF_CLK = ~REF_CLK;
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge REF_CLK);
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung access
      do begin
         @(posedge REF_CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge REF_CLK);
   endtask

   task automatic hosts(input int a, input int b, input int c, input int d);
      ep <= 16'(a);
      eh <= 16'(b);
      lp <= 16'(c);
      lh <= 16'(d);
   endtask

   task automatic wait_mode(input logic [2:0] m);
      for (int t = 0; t < 5000 && DIM_MODE !== m; t++) begin
         cyc(1);
      end
   endtask

   task automatic count_on(input int k);
      n = 0;
      repeat (k) begin
         @(posedge REF_CLK);
         n += int'(SWITCH_EN === 1'b1);
      end
   endtask

   // enable held high from idle: 5 us qualification, then the start wait
   task automatic start_chk(input int p);
      cyc(1000 + p / 2);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("state_wait", 32'(rd[4:3]), 32'h1);
      cyc(p / 2 + 50);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("state_decode", 32'(rd[4:3]), 32'h2);
   endtask

   function automatic logic [7:0] exp_duty(input int h, input int p);
      int v;
      v = (256 * h) / p;
      return (v > 255) ? 8'hFF : 8'(v);
   endfunction

   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      cyc(60000);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(54));
      cyc(4);
      RST <= 1'b0;
      cyc(2);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl_reset", rd, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl_rw", rd, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped_err", 32'(er), 32'h1);
      chk("unmapped_data", rd, 32'h0);
      hosts(1, 1, 1, 1);
      start_chk(P_START);
      hosts(40, 20, 1, 1);
      wait_mode(MD_PULSE);
      chk("pulse_mode", 32'(DIM_MODE), 32'(MD_PULSE));
      // first pass is the 150 ns corner
      for (int k = 0; k < 3; k++) begin
         hi = (k == 0) ? 30 : int'($urandom_range(34, 6));
         hosts(40, hi, 1, 1);
         cyc(80);
         count_on(400);
         chk("pulse_on", n, 10 * hi);
      end
      // one step of the full-scale walk has passed, the second not yet
      cyc(2800);
      chk("vref_ramp", 32'(VREF_CODE), 32'h1);
      hosts(1, 1, 1, 1);
      cyc(10);
      foreach (frow[i]) begin
         FAULT_CMP_IN <= frow[i][11:4];
         cyc(20);
         chk("fault_pin", 32'(FAULT_N_OE), 32'(frow[i][3]));
         chk("switch_en", 32'(SWITCH_EN), 32'(frow[i][2]));
         chk("cv_mode", 32'(CV_MODE), 32'(frow[i][1]));
         chk("min_on", 32'(MIN_ON_TIME), 32'(frow[i][0]));
      end
      hosts(1, 0, 1, 1);
      cyc(700);
      hosts(1, 1, 1, 1);
      start_chk(P_REEN);
      hosts(1, 1, 300, 250);
      wait_mode(MD_ANALOG);
      chk("analog_mode", 32'(DIM_MODE), 32'(MD_ANALOG));
      hi = int'($urandom_range(280, 20));
      hosts(1, 1, 300, hi);
      cyc(1500);
      apb(1'b0, ADDR_LEVEL, 32'h0);
      chk("duty", 32'(rd[7:0]), 32'(exp_duty(hi, 300)));
      hosts(1, 1, 1, 0);
      cyc(700);
      apb(1'b0, ADDR_LEVEL, 32'h0);
      chk("duty_low", 32'(rd[7:0]), 32'hFF);
      hosts(1, 1, 1, 1);
      cyc(700);
      apb(1'b0, ADDR_LEVEL, 32'h0);
      chk("duty_high", 32'(rd[7:0]), 32'h0);
      hosts(40, 20, 300, 150);
      wait_mode(MD_FLEX);
      chk("flex_mode", 32'(DIM_MODE), 32'(MD_FLEX));
      cyc(80);
      count_on(400);
      chk("flex_on", n, 200);
      SUPPLY_OK_IN <= 1'b0;
      hosts(1, 1, 1, 0);
      cyc(10);
      chk("supply_off", 32'(DIM_MODE), 32'(MD_NONE));
      SUPPLY_OK_IN <= 1'b1;
      cyc(1300);
      hosts(40, 30, 1, 0);
      wait_mode(MD_HYBRID);
      chk("hybrid_mode", 32'(DIM_MODE), 32'(MD_HYBRID));
      // duty 0x20 exactly keeps whichever region it came from
      foreach (hy[k]) begin
         hosts(40, hy[k], 1, 0);
         cyc(400);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("pwm_region", 32'(rd[11]), 32'(hx[k]));
      end
      hosts(40, 30, 1, 1);
      wait_mode(MD_FLEX);
      chk("hybrid_exit", 32'(DIM_MODE), 32'(MD_FLEX));
      tally_and_finish();
   end
endmodule
`default_nettype wire
